// >>> rtl/ssp_pkg.sv
// shared constants, register map and types of the sync serial slave port
package ssp_pkg;

    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h00;
    localparam logic [7:0] OFF_IRQ_ENABLES  = 8'h04;
    localparam logic [7:0] OFF_IRQ_PRIORITY = 8'h08;
    localparam logic [7:0] OFF_RX_STATUS    = 8'h0C;
    localparam logic [7:0] OFF_TX_BUFFER    = 8'h10;
    localparam logic [7:0] OFF_TX_STATUS    = 8'h14;
    localparam logic [7:0] OFF_RATE_GEN     = 8'h18;
    localparam logic [7:0] OFF_RX_BUFFER    = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CONTROL  = 8'h20;
    localparam logic [7:0] OFF_POWER_MODE   = 8'h24;

    // field positions in peripheral_irq_flags / enables
    localparam int RX_FLAG_BIT = 5;
    localparam int TX_FLAG_BIT = 4;
    // receive_status_control
    localparam int PORT_EN_BIT  = 7;
    localparam int RX_NINE_BIT  = 6;
    localparam int SINGLE_RX_BIT = 5;
    localparam int CONT_RX_BIT  = 4;
    localparam int ADDEN_BIT    = 3;
    localparam int FERR_BIT     = 2;
    localparam int OERR_BIT     = 1;
    localparam int RX9D_BIT     = 0;
    // transmit_status_control
    localparam int CLK_SRC_BIT  = 7;
    localparam int TX_NINE_BIT  = 6;
    localparam int TX_EN_BIT    = 5;
    localparam int SYNC_BIT     = 4;
    localparam int SENDB_BIT    = 3;
    localparam int BRGH_BIT     = 2;
    localparam int SHIFT_EMPTY_BIT = 1;
    localparam int TX_NINTH_BIT = 0;
    // irq_control_register
    localparam int GLOBAL_IRQ_BIT  = 7;
    localparam int PERIPH_GATE_BIT = 6;

    // reset values
    localparam logic [7:0] RX_STATUS_RESET = 8'h00;
    localparam logic [7:0] TX_STATUS_RESET = 8'h02;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int WORD_BITS  = 9;
    localparam int COUNT_BITS = 4;

    // shift clock edges seen by the system clock
    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } ssp_edge_s;

    typedef enum logic [1:0] {
        SSP_TX_IDLE,
        SSP_TX_SHIFT
    } ssp_tx_e;

endpackage : ssp_pkg

// >>> rtl/ssp_edge_sync.sv
// two-flop synchroniser plus edge detector for the external shift clock
module ssp_edge_sync
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // raw pin and synchronised edges
    input  wire logic              pin_in,
    output ssp_pkg::ssp_edge_s     edge_out
);
    import ssp_pkg::*;

    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign edge_out.rise  = sync & ~prev;
    assign edge_out.fall  = ~sync & prev;
    assign edge_out.level = sync;

endmodule : ssp_edge_sync

// >>> rtl/ssp_slave_port.sv
// synchronous slave serial port with axi4-lite register access
// How it works
// - slave mode when clock source clear, clocked mode and port enable set.
// - shift clock pin is input only; edges from outside shift the data.
// - transfers continue in any low-power mode; clock comes from outside.
// - slave transmit matches master transmit: buffer hand-off, flags, ninth bit.
// - first of two words moves to shifter at once; second waits in buffer.
// - empty flag stays clear while second waits; set after it loads.
// - empty flag with its interrupt enable gives wake request; vector needs global enable.
// - buffer write starts transmit; ninth bit loaded beforehand is sent.
// - single receive enable ignored; only continuous receive enable governs reception.
// - word clocked in during low power is still received.
// - completed word moves from receive shifter to receive buffer.
// - receive completion with enable wakes device; vector needs global enable.
// - receive full flag sets on completion; request raised when enabled.
// - receive buffer read returns low eight data bits.
// - clearing continuous receive enable clears error indications.
// - empty flag sets on hand-off, clears only on buffer write.
// - shifter empty flag is read-only, set when shifter empty, no interrupt.
// - port enable turns the pins into shift clock and serial data.
// - receive samples data on falling edge of shift clock.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
module ssp_slave_port
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    // axi4-lite slave
    input  wire logic [7:0]  s_awaddr_in,
    input  wire logic        s_awvalid_in,
    output logic             s_awready_out,
    input  wire logic [31:0] s_wdata_in,
    input  wire logic [3:0]  s_wstrb_in,
    input  wire logic        s_wvalid_in,
    output logic             s_wready_out,
    output logic [1:0]       s_bresp_out,
    output logic             s_bvalid_out,
    input  wire logic        s_bready_in,
    input  wire logic [7:0]  s_araddr_in,
    input  wire logic        s_arvalid_in,
    output logic             s_arready_out,
    output logic [31:0]      s_rdata_out,
    output logic [1:0]       s_rresp_out,
    output logic             s_rvalid_out,
    input  wire logic        s_rready_in,
    // serial pins
    input  wire logic        shift_timing_pin_in,
    input  wire logic        serial_line_pin_in,
    output logic             serial_line_pin_out,
    output logic             serial_line_pin_oe_out,
    // wake and interrupt
    output logic             wake_out,
    output logic             irq_vector_out
);
    import ssp_pkg::*;

    logic       rst_meta;
    logic       rst_n;
    ssp_edge_s  sck;
    logic       dat_meta;
    logic       dat_sync;

    logic [7:0] rx_ctl;
    logic [7:0] tx_ctl;
    logic [7:0] irq_en;
    logic [7:0] irq_pri;
    logic [7:0] rate_ctl;
    logic [7:0] irq_ctl;
    logic [1:0] power_mode;
    logic [7:0] tx_buf;
    logic       tx_buf_full;
    logic       tx_flag;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    ssp_tx_e    tx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [7:0] rx_buf;
    logic       rx_ninth;
    logic       rx_flag;
    logic       overrun;

    logic       slave_mode;
    logic       tx_done;
    logic       rx_done;
    logic [3:0] word_len;
    logic [3:0] rx_len;
    logic       aw_hold;
    logic       w_hold;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       wr_fire;
    logic       rd_fire;
    logic       txbuf_write;
    logic       rxbuf_read;

    function automatic logic [3:0] bits_of(input logic nine);
        return nine ? 4'h9 : 4'h8;
    endfunction : bits_of

    // reset release through two flops
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ssp_edge_sync u_sck_sync
    (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_n),
        .pin_in   (shift_timing_pin_in),
        .edge_out (sck)
    );

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dat_meta <= 1'b0;
            dat_sync <= 1'b0;
        end
        else
        begin
            dat_meta <= serial_line_pin_in;
            dat_sync <= dat_meta;
        end
    end

    assign slave_mode = rx_ctl[PORT_EN_BIT] & tx_ctl[SYNC_BIT] & ~tx_ctl[CLK_SRC_BIT];
    assign word_len   = bits_of(tx_ctl[TX_NINE_BIT]);
    assign rx_len     = bits_of(rx_ctl[RX_NINE_BIT]);

    // axi write channel capture, either order
    assign wr_fire = aw_hold & w_hold & ~s_bvalid_out;
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= BYTE_ZERO;
            w_data        <= BYTE_ZERO;
            w_lane0       <= 1'b0;
            s_awready_out <= 1'b1;
            s_wready_out  <= 1'b1;
            s_bvalid_out  <= 1'b0;
            s_bresp_out   <= RESP_OKAY;
        end
        else
        begin
            if (s_awvalid_in && s_awready_out)
            begin
                aw_hold       <= 1'b1;
                aw_addr       <= s_awaddr_in;
                s_awready_out <= 1'b0;
            end
            if (s_wvalid_in && s_wready_out)
            begin
                w_hold       <= 1'b1;
                w_data       <= s_wdata_in[7:0];
                w_lane0      <= s_wstrb_in[0];
                s_wready_out <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_bvalid_out <= 1'b1;
                s_bresp_out  <= (aw_addr > OFF_POWER_MODE || aw_addr[1:0] != 2'h0)
                                ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_bvalid_out && s_bready_in)
            begin
                s_bvalid_out  <= 1'b0;
                s_awready_out <= 1'b1;
                s_wready_out  <= 1'b1;
            end
        end
    end

    assign txbuf_write = wr_fire & w_lane0 & (aw_addr == OFF_TX_BUFFER);

    // control registers
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ctl     <= RX_STATUS_RESET;
            tx_ctl     <= TX_STATUS_RESET;
            irq_en     <= BYTE_ZERO;
            irq_pri    <= BYTE_ZERO;
            rate_ctl   <= BYTE_ZERO;
            irq_ctl    <= BYTE_ZERO;
            power_mode <= 2'h0;
        end
        else if (wr_fire && w_lane0)
        begin
            unique case (aw_addr)
                OFF_IRQ_ENABLES:  irq_en     <= w_data & 8'h37;
                OFF_IRQ_PRIORITY: irq_pri    <= w_data & 8'h37;
                OFF_RX_STATUS:    rx_ctl     <= w_data & 8'hF9;
                OFF_TX_STATUS:    tx_ctl     <= w_data & 8'hFD;
                OFF_RATE_GEN:     rate_ctl   <= w_data & 8'h1B;
                OFF_IRQ_CONTROL:  irq_ctl    <= w_data & 8'hC0;
                // power mode only tags state; port keeps running in it
                OFF_POWER_MODE:   power_mode <= w_data[1:0];
                default:          ;
            endcase
        end
    end

    // buffer write, flag clears only on write
    // immediate hand-off, flag after reload, same as master
    assign tx_done = (tx_state == SSP_TX_SHIFT) && sck.rise && (tx_cnt == 4'h1);
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_buf      <= BYTE_ZERO;
            tx_buf_full <= 1'b0;
            tx_flag     <= 1'b1;
            tx_shift    <= 9'h000;
            tx_cnt      <= 4'h0;
            tx_state    <= SSP_TX_IDLE;
        end
        else if (!slave_mode || !tx_ctl[TX_EN_BIT])
        begin
            tx_state <= SSP_TX_IDLE;
            tx_cnt   <= 4'h0;
            if (txbuf_write)
            begin
                tx_buf      <= w_data;
                tx_buf_full <= 1'b1;
                tx_flag     <= 1'b0;
            end
        end
        else
        begin
            unique case (tx_state)
                SSP_TX_IDLE:
                begin
                    if (tx_buf_full)
                    begin
                        tx_shift    <= {tx_ctl[TX_NINTH_BIT], tx_buf};
                        tx_cnt      <= word_len;
                        tx_state    <= SSP_TX_SHIFT;
                        tx_buf_full <= 1'b0;
                        tx_flag     <= 1'b1;
                    end
                end
                SSP_TX_SHIFT:
                begin
                    if (sck.rise)
                    begin
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_cnt   <= tx_cnt - 4'h1;
                        if (tx_done)
                        begin
                            tx_state <= SSP_TX_IDLE;
                        end
                    end
                end
            endcase
            if (txbuf_write)
            begin
                tx_buf      <= w_data;
                tx_buf_full <= 1'b1;
                tx_flag     <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_line_pin_out    <= 1'b0;
            serial_line_pin_oe_out <= 1'b0;
        end
        else
        begin
            serial_line_pin_out    <= tx_shift[0];
            serial_line_pin_oe_out <= slave_mode & tx_ctl[TX_EN_BIT]
                                      & ~rx_ctl[CONT_RX_BIT];
        end
    end

    // only continuous enable, falling edge sample
    assign rx_done = slave_mode && rx_ctl[CONT_RX_BIT] && sck.fall && (rx_cnt == rx_len - 4'h1);
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_shift <= 9'h000;
            rx_cnt   <= 4'h0;
        end
        else if (!slave_mode || !rx_ctl[CONT_RX_BIT])
        begin
            rx_cnt <= 4'h0;
        end
        else if (sck.fall)
        begin
            rx_shift <= {dat_sync, rx_shift[8:1]};
            rx_cnt   <= rx_done ? 4'h0 : rx_cnt + 4'h1;
        end
    end

    assign rxbuf_read = rd_fire && (s_araddr_in == OFF_RX_BUFFER);

    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_buf   <= BYTE_ZERO;
            rx_ninth <= 1'b0;
            rx_flag  <= 1'b0;
            overrun  <= 1'b0;
        end
        else
        begin
            if (rx_done && (!rx_flag || rxbuf_read))
            begin
                rx_buf   <= rx_ctl[RX_NINE_BIT] ? rx_shift[8:1] : {dat_sync, rx_shift[8:2]};
                rx_ninth <= rx_ctl[RX_NINE_BIT] ? dat_sync : 1'b0;
                rx_flag  <= 1'b1;
            end
            else if (rxbuf_read)
            begin
                rx_flag <= 1'b0;
            end
            if (rx_done && rx_flag && !rxbuf_read)
            begin
                overrun <= 1'b1;
            end
            else if (!rx_ctl[CONT_RX_BIT])
            begin
                overrun <= 1'b0;
            end
        end
    end

    // wake on enabled flag, vector gated globally
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_out       <= 1'b0;
            irq_vector_out <= 1'b0;
        end
        else
        begin
            wake_out       <= (tx_flag & irq_en[TX_FLAG_BIT]) | (rx_flag & irq_en[RX_FLAG_BIT]);
            irq_vector_out <= ((tx_flag & irq_en[TX_FLAG_BIT]) | (rx_flag & irq_en[RX_FLAG_BIT]))
                              & irq_ctl[GLOBAL_IRQ_BIT] & irq_ctl[PERIPH_GATE_BIT];
        end
    end

    // axi read channel; low eight bits, shifter empty status
    assign rd_fire = s_arvalid_in & s_arready_out;
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_arready_out <= 1'b1;
            s_rvalid_out  <= 1'b0;
            s_rdata_out   <= 32'h0000_0000;
            s_rresp_out   <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_arready_out <= 1'b0;
            s_rvalid_out  <= 1'b1;
            s_rresp_out   <= RESP_OKAY;
            unique case (s_araddr_in)
                OFF_IRQ_FLAGS:    s_rdata_out <= {26'h0, rx_flag, tx_flag, 4'h0};
                OFF_IRQ_ENABLES:  s_rdata_out <= {24'h0, irq_en};
                OFF_IRQ_PRIORITY: s_rdata_out <= {24'h0, irq_pri};
                OFF_RX_STATUS:    s_rdata_out <= {24'h0, rx_ctl[7:3], 1'b0, overrun, rx_ninth};
                OFF_TX_STATUS:    s_rdata_out <= {24'h0, tx_ctl[7:2],
                                                  tx_state == SSP_TX_IDLE, tx_ctl[0]};
                OFF_RATE_GEN:     s_rdata_out <= {24'h0, rate_ctl};
                OFF_RX_BUFFER:    s_rdata_out <= {24'h0, rx_buf};
                OFF_IRQ_CONTROL:  s_rdata_out <= {24'h0, irq_ctl};
                OFF_POWER_MODE:   s_rdata_out <= {30'h0, power_mode};
                default:
                begin
                    s_rdata_out <= 32'h0000_0000;
                    s_rresp_out <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_rvalid_out && s_rready_in)
        begin
            s_rvalid_out  <= 1'b0;
            s_arready_out <= 1'b1;
        end
    end

    // flag clear while a second word waits behind a busy shifter
    wait_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (tx_buf_full && tx_state == SSP_TX_SHIFT) |-> !tx_flag)
        else $error("empty flag set while word waits");

    flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        txbuf_write |=> !tx_flag)
        else $error("buffer write did not clear empty flag");

    // handoff in one cycle when idle
    handoff_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (slave_mode && tx_ctl[TX_EN_BIT] && tx_state == SSP_TX_IDLE && tx_buf_full
         && !txbuf_write) |=> (tx_state == SSP_TX_SHIFT && tx_flag))
        else $error("word not handed to shifter");

    rx_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        rx_done |=> rx_flag)
        else $error("receive flag not set on completion");

    overrun_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (rx_done && rx_flag && !rxbuf_read) |=> (overrun && $stable(rx_buf)))
        else $error("overrun lost or data overwritten");

    err_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!rx_ctl[CONT_RX_BIT] && !rx_done) |=> !overrun)
        else $error("error not cleared");

    // no reception without continuous enable; count drops one cycle later
    rx_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !rx_ctl[CONT_RX_BIT] |-> (!rx_done ##1 (rx_cnt == 4'h0)))
        else $error("receive ran without continuous enable");

    // vector only with both global gates
    vector_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        irq_vector_out |-> ($past(irq_ctl[GLOBAL_IRQ_BIT]) && $past(irq_ctl[PERIPH_GATE_BIT])
            && wake_out))
        else $error("vector without global enable");

endmodule : ssp_slave_port

// >>> dv/ssp_master_model.sv
// external master model driving shift clock and data
module ssp_master_model
(
    // clock
    input  wire logic clk_in,
    // link pins
    input  wire logic line_in,
    output logic      sck_out,
    output logic      sdo_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sck_out = 1'b0;
        sdo_out = 1'b0;
    end
    task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = 9'h000;
        @(posedge clk_in);
        // start opposite to bit0 so a rising-edge sampler would miss it
        sdo_out <= ~tx[0];
        for (int i = 0; i < n; i++)
        begin
            repeat (16) @(posedge clk_in);
            rx[i] = line_in;
            sck_out <= 1'b1;
            // data moves after the rise and stands across the fall
            repeat (4) @(posedge clk_in);
            sdo_out <= tx[i];
            repeat (12) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (16) @(posedge clk_in);
        // released line shows inverse of last bit
        sdo_out <= ~sdo_out;
    endtask : xfer
endmodule : ssp_master_model

// >>> dv/testbench.sv
// self-checking bench of the sync serial slave port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssp_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0]  ws = 4'h0;
    logic        awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
    logic        awr, wrd, bv, arr, rv, sck, sdo, sdi, oe, wake, vec;
    logic [31:0] rdat;
    logic [1:0]  br, rr;
    logic [33:0] exp_q[$];
    logic [33:0] bexp_q[$];
    logic [31:0] seed = 32'hEF5F;
    logic [8:0]  got, w1, w2;
    int          n_fail = 0, checked = 0, cyc = 0;
    wire logic   line = oe ? sdi : sdo;

    always #2.5 clk = ~clk;

    ssp_slave_port dut_u (.sys_clk_in(clk), .nrst_in(nrst),
        .s_awaddr_in(awa), .s_awvalid_in(awv), .s_awready_out(awr),
        .s_wdata_in(wd), .s_wstrb_in(ws), .s_wvalid_in(wv), .s_wready_out(wrd),
        .s_bresp_out(br), .s_bvalid_out(bv), .s_bready_in(bq),
        .s_araddr_in(ara), .s_arvalid_in(arv), .s_arready_out(arr),
        .s_rdata_out(rdat), .s_rresp_out(rr), .s_rvalid_out(rv), .s_rready_in(rq),
        .shift_timing_pin_in(sck), .serial_line_pin_in(line),
        .serial_line_pin_out(sdi), .serial_line_pin_oe_out(oe),
        .wake_out(wake), .irq_vector_out(vec));
    ssp_master_model mm_u (.clk_in(clk), .line_in(line), .sck_out(sck), .sdo_out(sdo));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic test_done();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bexp_q.push_back(34'(RESP_OKAY));
        awa <= a;
        wd <= {24'h000000, d};
        ws <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        bq <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wrd)
                wv <= 1'b0;
        end
        while (!(bq && bv));
        bq <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back({r, 24'h000000, e});
        ara <= a;
        arv <= 1'b1;
        rq <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arv && arr)
                arv <= 1'b0;
        end
        while (!(rq && rv));
        rq <= 1'b0;
    endtask : rd

    // read answers against oldest note
    always @(posedge clk)
        if (rv && rq)
            chk("rdata", {rr, rdat}, exp_q.pop_front());

    // write answers against oldest note
    always @(posedge clk)
        if (bv && bq)
            chk("bresp", 34'(br), bexp_q.pop_front());

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFF_TX_STATUS, RESP_OKAY, TX_STATUS_RESET);
        rd(OFF_IRQ_FLAGS, RESP_OKAY, 8'h10);
        rd(8'h30, RESP_SLVERR, BYTE_ZERO);
        chk("oe", 34'(oe), 34'h0);
        // slave transmit, two words, then sleep
        wr(OFF_RX_STATUS, 8'h80);
        wr(OFF_TX_STATUS, 8'h71);
        wr(OFF_IRQ_ENABLES, 8'h10);
        wr(OFF_IRQ_CONTROL, 8'hC0);
        seed = xs(seed);
        w1 = {1'b1, seed[7:0]};
        w2 = {1'b1, seed[15:8]};
        wr(OFF_TX_BUFFER, w1[7:0]);
        wr(OFF_TX_BUFFER, w2[7:0]);
        wr(OFF_POWER_MODE, 8'h01);
        rd(OFF_IRQ_FLAGS, RESP_OKAY, 8'h00);
        rd(OFF_TX_STATUS, RESP_OKAY, 8'h71);
        chk("wake", 34'(wake), 34'h0);
        chk("oe", 34'(oe), 34'h1);
        mm_u.xfer(9, 9'h000, got);
        chk("tx word", 34'(got), 34'(w1));
        chk("wake vec", 34'({wake, vec}), 34'h3);
        mm_u.xfer(9, 9'h000, got);
        chk("tx word", 34'(got), 34'(w2));
        rd(OFF_TX_STATUS, RESP_OKAY, 8'h73);
        // nine-bit receive, single enable also set
        wr(OFF_IRQ_ENABLES, 8'h20);
        wr(OFF_TX_STATUS, 8'h10);
        wr(OFF_RX_STATUS, 8'hF0);
        chk("oe", 34'(oe), 34'h0);
        seed = xs(seed);
        w1 = seed[8:0];
        mm_u.xfer(9, w1, got);
        chk("wake vec", 34'({wake, vec}), 34'h3);
        rd(OFF_IRQ_FLAGS, RESP_OKAY, 8'h30);
        rd(OFF_RX_STATUS, RESP_OKAY, {7'h78, w1[8]});
        rd(OFF_RX_BUFFER, RESP_OKAY, w1[7:0]);
        rd(OFF_IRQ_FLAGS, RESP_OKAY, 8'h10);
        // two words with no read between
        seed = xs(seed);
        w1 = {1'b0, seed[7:0]};
        w2 = {1'b0, seed[15:8]};
        mm_u.xfer(9, w1, got);
        mm_u.xfer(9, w2, got);
        rd(OFF_RX_STATUS, RESP_OKAY, 8'hF2);
        rd(OFF_RX_BUFFER, RESP_OKAY, w1[7:0]);
        wr(OFF_RX_STATUS, 8'hE0);
        rd(OFF_RX_STATUS, RESP_OKAY, 8'hE0);
        test_done();
    end
endmodule : testbench
